// File: rtl/crosspoint_serial_program_logic.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// R1 - a full program is 193 bits: clamp bit plus 32 six-bit output slots
// R2 - controller drives select low before shifting data
// R3 - strobe low while shifting passes every shift state to matrix
// R4 - data sampled on each serial clock rising edge, shifting one bit
// R5 - each output has a 5-bit select and one enable bit
// R6 - enable bit 0 disables output and ignores its select
// R7 - first bit is global clamp enable, 1 enables all clamps
// R8 - output slots arrive from output 31 down to output 0
// R9 - in each slot enable comes first, then select msb to lsb
// R10 - second rank transparent while update strobe is low
// R11 - chained devices pass data on; last device data sent first
// R12 - reset low disables every output
// R13 - reset clears both shift rank and output rank
// R14 - controller holds update high before releasing reset
// R15 - controller loads a full word before first update pulse
// R16 - serial out presents bit leaving last shift stage
// R17 - select high ignores serial clock and holds the shift rank
module crosspoint_serial_program_logic
  import xpoint_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial programming pins
  input wire logic serialClk,
  input wire logic serialDataIn,
  input wire logic selectN,
  input wire logic updateN,
  input wire logic deviceResetN,
  output logic serialDataOut,
  // matrix control
  output logic clampEnable,
  output logic [NUM_OUTPUTS-1:0] outputEnable,
  output logic [NUM_OUTPUTS*SELECT_WIDTH-1:0] inputSelect
);
  // pin order inside the synchroniser bank
  localparam int PIN_COUNT = 5;
  localparam int PIN_SCLK = 0;
  localparam int PIN_DATA = 1;
  localparam int PIN_SEL = 2;
  localparam int PIN_UPD = 3;
  localparam int PIN_RST = 4;

  // raw and filtered pin levels
  logic [PIN_COUNT-1:0] pinRaw;
  logic [PIN_COUNT-1:0] pinLevel;
  logic sclkLevel;
  logic dataLevel;
  logic selLevel;
  logic updActive;
  logic rstLevel;

  // serial clock edge detection
  logic sclkPrev_r;
  logic sclkRise;
  logic shiftEdge;

  // resets
  logic pinReset;
  logic devReset;

  // first rank
  logic [WORD_BITS-1:0] shift_r;
  logic [WORD_BITS-1:0] shift_nxt;

  // global clamp in the second rank
  localparam logic CLAMP_INIT = LATCH_RESET[CLAMP_POS];
  logic clampBit;
  logic clamp_r;
  logic clamp_nxt;

  // strobe inverted so the synchroniser's reset zero means no update,
  // which keeps a false update away from the first cycles after reset
  // serial clock and data
  assign pinRaw[PIN_SCLK] = serialClk;
  assign pinRaw[PIN_DATA] = serialDataIn;

  // control strobes
  assign pinRaw[PIN_SEL] = selectN;
  assign pinRaw[PIN_UPD] = !updateN;
  assign pinRaw[PIN_RST] = deviceResetN;

  // every pin arrives from outside the clock domain
  // one filter per pin; latency is four clocks
  generate
    for (genvar p = 0; p < PIN_COUNT; p++) begin : gPin
      pin_sync syncPin (
        .clk(clk),
        .reset(reset),
        .pinIn(pinRaw[p]),
        .level(pinLevel[p])
      );
    end
  endgenerate

  // filtered clock and data
  assign sclkLevel = pinLevel[PIN_SCLK];
  assign dataLevel = pinLevel[PIN_DATA];

  // filtered controls
  assign selLevel = pinLevel[PIN_SEL];
  assign updActive = pinLevel[PIN_UPD];
  assign rstLevel = pinLevel[PIN_RST];

  // pin reset reads low while its synchroniser still holds zero,
  // so the device stays cleared until the pin is known high
  assign pinReset = !rstLevel; // R12
  assign devReset = reset || pinReset; // R13

  // refused edges still track the level, so selecting mid-pulse is no edge
  always_ff @(posedge clk) begin
    if (reset) begin
      sclkPrev_r <= 1'b0;
    end else begin
      sclkPrev_r <= sclkLevel;
    end
  end

  // rising edge of the filtered serial clock
  assign sclkRise = sclkLevel && !sclkPrev_r; // R4
  // data filtered with the same latency as the clock, so setup holds
  // deselected: edges refused, contents held
  assign shiftEdge = sclkRise && !selLevel; // R17 R2

  // bits enter at the low end; the clamp bit ends at the top
  always_comb begin
    shift_nxt = shift_r;
    if (shiftEdge) begin
      shift_nxt = {shift_r[WORD_BITS-2:0], dataLevel}; // R4 R1
    end
  end

  // one rank of flops, no buffering beyond it
  always_ff @(posedge clk) begin
    if (devReset) begin
      shift_r <= SHIFT_RESET; // R13
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // chain output is the bit shifted out of the top stage
  assign serialDataOut = shift_r[WORD_BITS-1]; // R16 R11

  assign clampBit = shift_r[CLAMP_POS]; // R7 R1

  // second rank modelled as a clocked follower while the strobe is low;
  // shifting with the strobe low therefore shows every intermediate word
  // limitation: a strobe pulse shorter than the filter window is never seen
  always_comb begin
    clamp_nxt = clamp_r;
    if (updActive) begin
      clamp_nxt = clampBit; // R10 R3
    end
  end

  always_ff @(posedge clk) begin
    if (devReset) begin
      clamp_r <= CLAMP_INIT; // R13
    end else begin
      clamp_r <= clamp_nxt;
    end
  end

  assign clampEnable = clamp_r; // R7

  // slot k counted from the low end holds output k, so output 31 came first
  // enable first then select, so the enable sits at the top of each slot
  generate
    for (genvar k = 0; k < NUM_OUTPUTS; k++) begin : gSlot
      // reset leaves every output disabled
      localparam logic ENABLE_INIT = LATCH_RESET[k*SLOT_WIDTH+OUTPUT_ENABLE_BIT];
      localparam logic [SELECT_WIDTH-1:0] SELECT_INIT = LATCH_RESET[k*SLOT_WIDTH +: SELECT_WIDTH];
      logic [SLOT_WIDTH-1:0] slot;
      logic slotEnable;
      logic [SELECT_WIDTH-1:0] slotSelect;
      logic enable_r;
      logic enable_nxt;
      logic [SELECT_WIDTH-1:0] select_r;
      logic [SELECT_WIDTH-1:0] select_nxt;

      assign slot = shift_r[k*SLOT_WIDTH +: SLOT_WIDTH]; // R8 R5
      assign slotEnable = slot[OUTPUT_ENABLE_BIT]; // R9

      // select cleared when disabled, so nothing is routed
      always_comb begin
        slotSelect = '0;
        if (slotEnable) begin
          slotSelect = slot[SELECT_MSB:SELECT_LSB]; // R6 R9
        end
      end

      // the second rank per output, held while the strobe is high
      always_comb begin
        enable_nxt = enable_r;
        select_nxt = select_r;
        if (updActive) begin
          enable_nxt = slotEnable; // R10 R3
          select_nxt = slotSelect;
        end
      end

      always_ff @(posedge clk) begin
        if (devReset) begin
          enable_r <= ENABLE_INIT; // R12 R13
          select_r <= SELECT_INIT; // R13
        end else begin
          enable_r <= enable_nxt;
          select_r <= select_nxt;
        end
      end

      assign outputEnable[k] = enable_r; // R12
      assign inputSelect[k*SELECT_WIDTH +: SELECT_WIDTH] = select_r; // R6
    end
  endgenerate
endmodule
`default_nettype wire

// File: rtl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// three-stage synchroniser; a change counts once stages two and three agree
module pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pin and filtered level
  input wire logic pinIn,
  output logic level
);
  import xpoint_pkg::*;
  logic [2:0] stage_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      stage_r <= SYNC_RESET;
    end else begin
      stage_r <= {stage_r[1:0], pinIn};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      level <= 1'b0;
    end else if (stage_r[1] == stage_r[2]) begin
      level <= stage_r[2];
    end
  end
endmodule
`default_nettype wire

// File: rtl/xpoint_pkg.sv
package xpoint_pkg;
  localparam int NUM_OUTPUTS = 32;
  localparam int SELECT_WIDTH = 5;
  localparam int SLOT_WIDTH = 6;
  localparam int WORD_BITS = 1 + NUM_OUTPUTS * SLOT_WIDTH;
  localparam int CLAMP_POS = WORD_BITS - 1;
  localparam int OUTPUT_ENABLE_BIT = 5;
  localparam int SELECT_MSB = 4;
  localparam int SELECT_LSB = 0;
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = '0;
  localparam logic [WORD_BITS-1:0] LATCH_RESET = '0;
  localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage

// File: test/crosspoint_serial_program_logic_bench.sv
`timescale 1ns/1ns
`default_nettype none
module crosspoint_serial_program_logic_bench;
  import xpoint_pkg::*;
  logic clk = 1'b0, reset = 1'b1, updateN = 1'b1, deviceResetN = 1'b1;
  logic serialClk, serialDataIn, selectN, serialDataOut, clampEnable;
  logic [NUM_OUTPUTS-1:0] outputEnable;
  logic [NUM_OUTPUTS*SELECT_WIDTH-1:0] inputSelect;
  logic [31:0] seed = 32'h3eba648a;
  logic [WORD_BITS-1:0] w, cur = '0;
  int errCount = 0, samplesChecked = 0, cycles = 0;
  wire logic [WORD_BITS-1:0] mat = {clampEnable, outputEnable, inputSelect};
  always #5 clk = ~clk;
  always @(posedge clk) if (cycles++ > 40000) begin
    errCount++;
    testDone;
  end
  xp_host host(.clk, .serialClk, .serialDataIn, .selectN);
  crosspoint_serial_program_logic dut(.clk, .reset, .serialClk, .serialDataIn, .selectN,
    .updateN, .deviceResetN, .serialDataOut, .clampEnable, .outputEnable, .inputSelect);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [WORD_BITS-1:0] want(input logic [WORD_BITS-1:0] v);
    want = {v[CLAMP_POS], 192'h0};
    for (int k = 0; k < NUM_OUTPUTS; k++) begin
      want[160 + k] = v[6 * k + 5];
      want[5 * k +: 5] = v[6 * k + 5] ? v[6 * k +: 5] : 5'h0;
    end
  endfunction
  task automatic check(input string name, input logic [WORD_BITS-1:0] e, g);
    samplesChecked++;
    if (g !== e) begin
      errCount++;
      $display("BAD %s exp %h got %h", name, e, g);
    end
  endtask
  task automatic testDone;
    $display("%0d checks, %0d mismatches", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (8) @(negedge clk);
    check("reset", '0, mat);
    for (int t = 0; t < 4; t++) begin
      for (int j = 0; j < 7; j++) begin
        seed = xs(seed);
        w = {w[160:0], seed};
      end
      if (t == 0) w = '1;
      // last word goes out deselected and must leave everything as it was
      host.send(w, t == 3);
      if (t < 3) cur = w;
      repeat (8) @(negedge clk);
      check("dout", {192'h0, cur[CLAMP_POS]}, {192'h0, serialDataOut});
      updateN = 1'b0;
      repeat (8) @(negedge clk);
      updateN = 1'b1;
      check("matrix", want(cur), mat);
      $display("word %0d done", t);
    end
    deviceResetN = 1'b0;
    repeat (8) @(negedge clk);
    check("devreset", '0, mat);
    $display("device reset done");
    deviceResetN = 1'b1;
    repeat (8) @(negedge clk);
    updateN = 1'b0;
    for (int j = 0; j < 7; j++) begin
      seed = xs(seed);
      w = {w[160:0], seed};
    end
    // strobe held low while shifting: matrix follows the shift rank live
    host.send(w, 1'b0);
    repeat (8) @(negedge clk);
    check("live", want(w), mat);
    check("livedout", {192'h0, w[CLAMP_POS]}, {192'h0, serialDataOut});
    updateN = 1'b1;
    $display("live update done");
    testDone;
  end
endmodule
bind crosspoint_serial_program_logic xp_props props(.clk, .reset, .selectN, .updateN,
  .deviceResetN, .serialClk, .serialDataOut, .clampEnable, .outputEnable, .inputSelect);
`default_nettype wire

// File: test/xp_host.sv
`timescale 1ns/1ns
`default_nettype none
module xp_host
  import xpoint_pkg::*;
(
  input wire logic clk,
  output logic serialClk = 1'b0,
  output logic serialDataIn = 1'b0,
  output logic selectN = 1'b0
);
  // clock stands still between frames; idle data shows the inverse, never a stale bit
  task automatic send(input logic [WORD_BITS-1:0] w, input logic off);
    selectN = off;
    for (int i = CLAMP_POS; i >= 0; i--) begin
      serialDataIn = w[i];
      repeat (8) @(negedge clk);
      serialClk = 1'b1;
      repeat (8) @(negedge clk);
      serialClk = 1'b0;
    end
    serialDataIn = ~w[0];
  endtask
endmodule
`default_nettype wire

// File: test/xp_props.sv
`timescale 1ns/1ns
`default_nettype none
module xp_props
  import xpoint_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial pins
  input wire logic selectN,
  input wire logic updateN,
  input wire logic deviceResetN,
  input wire logic serialClk,
  input wire logic serialDataOut,
  // matrix
  input wire logic clampEnable,
  input wire logic [NUM_OUTPUTS-1:0] outputEnable,
  input wire logic [NUM_OUTPUTS*SELECT_WIDTH-1:0] inputSelect
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  wire logic [WORD_BITS-1:0] m = {clampEnable, outputEnable, inputSelect};
  // eight cycles covers the pin filter latency with margin
  sequence devHeld;
    !deviceResetN [*8];
  endsequence
  a_reset_clear: assert property ($fell(reset) |-> !m && !serialDataOut)
    else $error("reset");
  a_devrst_clear: assert property (devHeld |-> !m && !serialDataOut)
    else $error("devreset");
  a_matrix_hold: assert property ((deviceResetN && updateN) [*6] |=> $stable(m))
    else $error("hold");
  a_desel_hold: assert property ((deviceResetN && selectN) [*8] |=> $stable(serialDataOut))
    else $error("desel");
  a_quiet_hold: assert property ((deviceResetN && !serialClk) [*8] |=> $stable(serialDataOut))
    else $error("quiet");
  a_upd_follow: assert property ((!updateN && !serialClk) [*8]
    |-> clampEnable == serialDataOut) else $error("follow");
  a_slot_low: assert property (!outputEnable[0] |-> !inputSelect[4:0])
    else $error("slot0");
  a_slot_high: assert property (!outputEnable[31] |-> !inputSelect[159:155])
    else $error("slot31");
endmodule
`default_nettype wire
